/* src/ext_irq_regs.svh */
`ifndef EXT_IRQ_REGS_SVH
`define EXT_IRQ_REGS_SVH

`define EXT_IRQ_COUNT 4
`define CLOCK_PERIOD_NS 5
`define PHASE_HALF_NS 10
`define PHASE_HALF_CYC (`PHASE_HALF_NS / `CLOCK_PERIOD_NS)
`define PHASE_CNT_W 2
`define IRQ_ACK_RST 1'b1
`define PHASE_RST 1'b0

`endif

/* src/ext_irq_pkg.sv */
package ext_irq_pkg;
    typedef enum logic [1:0] {
        ACK_IDLE = 2'b00,
        ACK_WAIT = 2'b01,
        ACK_LOW = 2'b10
    } ack_state_e;

    typedef logic [3:0] irq_vec_t;
endpackage : ext_irq_pkg

/* src/ext_irq_sync.sv */
`timescale 1ns/1ps
module ext_irq_sync #(
    parameter int W = 4
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] stage1;

    // Stage one is read only by stage two
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= '1;
            sync_out <= '1;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : ext_irq_sync

/* src/ext_irq_sample_ack.sv */
`timescale 1ns/1ps
`include "ext_irq_regs.svh"
module ext_irq_sample_ack
    import ext_irq_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [3:0] ext_irq_lines_n,
    input wire logic fetch_boundary,
    input wire logic [3:0] cpu_irq_enable,
    input wire logic [3:0] dma_irq_enable,
    input wire logic ack_decode_start,
    output logic phase_one_clock,
    output logic irq_ack_out,
    output logic [3:0] irq_pending,
    output logic cpu_irq_take,
    output logic [3:0] cpu_irq_vec,
    output logic dma_irq_take,
    output logic [3:0] dma_irq_vec
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Lowest index wins when several lines are pending
    function automatic irq_vec_t lowest_one(input irq_vec_t v);
        irq_vec_t r;
        r = '0;
        for (int i = `EXT_IRQ_COUNT - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = '0;
                r[i] = 1'b1;
            end
        end
        return r;
    endfunction : lowest_one

    // ------------------------------------------------------------
    // Phase one clock divider
    // ------------------------------------------------------------
    localparam logic [`PHASE_CNT_W-1:0] HALF_LAST =
        `PHASE_CNT_W'(`PHASE_HALF_CYC - 1);

    logic [`PHASE_CNT_W-1:0] phase_cnt;
    logic half_end;
    logic rise_en;
    logic fall_en;

    assign half_end = (phase_cnt == HALF_LAST);
    assign rise_en = half_end && !phase_one_clock;
    assign fall_en = half_end && phase_one_clock;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            phase_cnt <= '0;
            phase_one_clock <= `PHASE_RST;
        end else if (half_end) begin
            phase_cnt <= '0;
            phase_one_clock <= !phase_one_clock;
        end else begin
            phase_cnt <= phase_cnt + `PHASE_CNT_W'(1);
        end
    end

    // ------------------------------------------------------------
    // Request synchronisation and sampling
    // ------------------------------------------------------------
    logic [3:0] lines_sync_n;
    logic [3:0] line_act;

    ext_irq_sync #(.W(`EXT_IRQ_COUNT)) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .async_in(ext_irq_lines_n),
        .sync_out(lines_sync_n)
    );

    // A change just before the edge may miss it and land a phase cycle late
    assign line_act = ~lines_sync_n;

    irq_vec_t cpu_pick;
    irq_vec_t dma_pick;
    irq_vec_t take_clear;

    assign cpu_pick = lowest_one(irq_pending & cpu_irq_enable);
    assign dma_pick = lowest_one(irq_pending & dma_irq_enable);
    // Taking is gated to the fetch boundary only
    assign take_clear = fetch_boundary ? (cpu_pick | dma_pick) : '0;

    genvar gi;
    generate
        for (gi = 0; gi < `EXT_IRQ_COUNT; gi++) begin : g_line
            // Level at the falling edge sets; a set beats a same-cycle clear
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    irq_pending[gi] <= 1'b0;
                end else if (fall_en && line_act[gi]) begin
                    irq_pending[gi] <= 1'b1;
                end else if (take_clear[gi]) begin
                    irq_pending[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Hand-off to core and DMA
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cpu_irq_take <= 1'b0;
            cpu_irq_vec <= '0;
            dma_irq_take <= 1'b0;
            dma_irq_vec <= '0;
        end else begin
            cpu_irq_take <= fetch_boundary && (cpu_pick != '0);
            cpu_irq_vec <= fetch_boundary ? cpu_pick : '0;
            dma_irq_take <= fetch_boundary && (dma_pick != '0);
            dma_irq_vec <= fetch_boundary ? dma_pick : '0;
        end
    end

    // ------------------------------------------------------------
    // Acknowledge output
    // ------------------------------------------------------------
    // Timed by phase edges only, so a stretched decode cannot widen it
    ack_state_e ack_state;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ack_state <= ACK_IDLE;
            irq_ack_out <= `IRQ_ACK_RST;
        end else begin
            unique case (ack_state)
                ACK_IDLE: begin
                    if (ack_decode_start && rise_en) begin
                        ack_state <= ACK_LOW;
                        irq_ack_out <= 1'b0;
                    end else if (ack_decode_start) begin
                        ack_state <= ACK_WAIT;
                    end
                end
                ACK_WAIT: begin
                    if (rise_en) begin
                        ack_state <= ACK_LOW;
                        irq_ack_out <= 1'b0;
                    end
                end
                ACK_LOW: begin
                    if (rise_en) begin
                        ack_state <= ACK_IDLE;
                        irq_ack_out <= 1'b1;
                    end
                end
                default: begin
                    ack_state <= ACK_IDLE;
                    irq_ack_out <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [3:0] pend_past;
    logic [3:0] act_past;
    logic fall_past;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pend_past <= '0;
            act_past <= '0;
            fall_past <= 1'b0;
        end else begin
            pend_past <= irq_pending;
            act_past <= line_act;
            fall_past <= fall_en;
        end
    end

    sequence ack_low_phase;
        !irq_ack_out [*4] ##1 irq_ack_out;
    endsequence

    sequence ack_enter_low;
        $fell(irq_ack_out) && $rose(phase_one_clock);
    endsequence

    chk_ack_fall_edge: assert property (
        @(posedge clock) disable iff (!rst_n)
        $fell(irq_ack_out) |-> $rose(phase_one_clock))
        else $error("ack fell off a phase rising edge");

    chk_ack_rise_edge: assert property (
        @(posedge clock) disable iff (!rst_n)
        $rose(irq_ack_out) |-> $rose(phase_one_clock))
        else $error("ack rose off a phase rising edge");

    chk_ack_one_cycle: assert property (
        @(posedge clock) disable iff (!rst_n)
        ack_enter_low |-> ack_low_phase)
        else $error("ack low width not one phase cycle");

    chk_ack_follows_req: assert property (
        @(posedge clock) disable iff (!rst_n)
        (ack_state == ACK_IDLE && ack_decode_start)
            |-> ##[0:4] (irq_ack_out == 1'b0))
        else $error("ack did not fall after decode start");

    chk_sample_level: assert property (
        @(posedge clock) disable iff (!rst_n)
        fall_past |-> ((irq_pending & act_past) == act_past))
        else $error("active level at falling edge not captured");

    chk_set_only_fall: assert property (
        @(posedge clock) disable iff (!rst_n)
        !fall_past |-> ((irq_pending & ~pend_past) == 4'h0))
        else $error("pending set away from the sampling edge");

    chk_take_boundary: assert property (
        @(posedge clock) disable iff (!rst_n)
        (cpu_irq_take || dma_irq_take) |-> $past(fetch_boundary))
        else $error("request taken off a fetch boundary");

    chk_sync_depth: assert property (
        @(posedge clock) disable iff (!rst_n)
        ##2 (lines_sync_n == $past(ext_irq_lines_n, 2)))
        else $error("synchroniser depth is not two");

    generate
        for (gi = 0; gi < `EXT_IRQ_COUNT; gi++) begin : g_rearm
            // A take must never lock the line out of the next sample
            chk_rearm_rate: assert property (
                @(posedge clock) disable iff (!rst_n)
                $fell(irq_pending[gi]) ##[1:12] (fall_past && act_past[gi])
                    |-> irq_pending[gi])
                else $error("line not re-accepted after a take");
        end
    endgenerate
endmodule : ext_irq_sample_ack

/* dv/ext_irq_requester.sv */
`timescale 1ns/1ps
module ext_irq_requester (
    output logic [3:0] lines_n,
    input wire logic clock
);
    // Lines idle at the pull-up level, as released requesters leave them
    initial lines_n = 4'hf;

    // One phase cycle low: one sampling edge sees it, never a second
    task automatic raise(input int idx);
        @(negedge clock);
        lines_n[idx] = 1'b0;
        repeat (4) @(negedge clock);
        lines_n[idx] = 1'b1;
    endtask : raise
endmodule : ext_irq_requester

/* dv/ext_irq_sample_ack_test.sv */
`timescale 1ns/1ps
module ext_irq_sample_ack_test;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic fetch_boundary = 1'b0;
    logic [3:0] cpu_irq_enable = 4'h0;
    logic [3:0] dma_irq_enable = 4'h0;
    logic ack_decode_start = 1'b0;
    logic [3:0] lines_n;
    logic phase_one_clock, irq_ack_out, cpu_irq_take, dma_irq_take;
    logic [3:0] irq_pending, cpu_irq_vec, dma_irq_vec;
    int err_total = 0;
    int cmp_count = 0;
    int n;

    ext_irq_requester ext_irq_requester_i (.lines_n(lines_n), .clock(clock));

    ext_irq_sample_ack ext_irq_sample_ack_i (
        .clock(clock), .rst_n(rst_n), .ext_irq_lines_n(lines_n),
        .fetch_boundary(fetch_boundary), .cpu_irq_enable(cpu_irq_enable),
        .dma_irq_enable(dma_irq_enable), .ack_decode_start(ack_decode_start),
        .phase_one_clock(phase_one_clock), .irq_ack_out(irq_ack_out),
        .irq_pending(irq_pending), .cpu_irq_take(cpu_irq_take),
        .cpu_irq_vec(cpu_irq_vec), .dma_irq_take(dma_irq_take),
        .dma_irq_vec(dma_irq_vec)
    );

    always #2.5 clock = ~clock;

    // ----------------------------------------
    // Reporting
    // ----------------------------------------
    task automatic final_report();
        if (err_total == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report

    task automatic check_vec(input logic [3:0] got, input logic [3:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_vec

    task automatic check_bit(input logic got, input logic exp);
        check_vec({3'h0, got}, {3'h0, exp});
    endtask : check_bit

    task automatic stop_if_spent(input int lim);
        if (n == lim) begin
            err_total++;
            final_report();
        end
    endtask : stop_if_spent

    task automatic wait_pend(input int idx);
        n = 0;
        while (irq_pending[idx] !== 1'b1 && n < 20) begin
            @(negedge clock);
            n++;
        end
        if (n == 20) begin
            err_total++;
            final_report();
        end
    endtask : wait_pend

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic take_check(input logic [3:0] exp);
        fetch_boundary = 1'b1;
        @(negedge clock);
        fetch_boundary = 1'b0;
        check_bit(cpu_irq_take, 1'b1);
        check_vec(cpu_irq_vec, exp);
        check_bit(dma_irq_take, 1'b1);
        check_vec(dma_irq_vec, exp);
        @(negedge clock);
        check_vec(irq_pending, 4'h0);
    endtask : take_check

    task automatic test_detect();
        for (int i = 0; i < 4; i++) begin
            cpu_irq_enable = 4'h1 << i;
            dma_irq_enable = 4'h1 << i;
            ext_irq_requester_i.raise(i);
            wait_pend(i);
            // No fetch boundary yet, so the request must wait
            repeat (8) @(negedge clock);
            check_vec(irq_pending, 4'h1 << i);
            take_check(4'h1 << i);
        end
    endtask : test_detect

    task automatic test_rate();
        int takes;
        takes = 0;
        cpu_irq_enable = 4'h4;
        dma_irq_enable = 4'h0;
        fetch_boundary = 1'b1;
        fork
            begin
                ext_irq_requester_i.raise(2);
                repeat (4) @(negedge clock);
                ext_irq_requester_i.raise(2);
            end
            repeat (30) begin
                @(negedge clock);
                if (cpu_irq_take === 1'b1) takes++;
            end
        join
        fetch_boundary = 1'b0;
        check_vec(takes[3:0], 4'h2);
    endtask : test_rate

    task automatic test_ack();
        ack_decode_start = 1'b1;
        @(negedge clock);
        ack_decode_start = 1'b0;
        n = 0;
        while (irq_ack_out !== 1'b0 && n < 8) begin
            @(negedge clock);
            n++;
        end
        stop_if_spent(8);
        check_bit(phase_one_clock, 1'b1);
        // Stretched decode: a repeated start must not lengthen the pulse
        ack_decode_start = 1'b1;
        n = 0;
        while (irq_ack_out === 1'b0 && n < 8) begin
            @(negedge clock);
            ack_decode_start = 1'b0;
            n++;
        end
        stop_if_spent(8);
        check_vec(n[3:0], 4'h4);
        check_bit(phase_one_clock, 1'b1);
    endtask : test_ack

    // Two lines at once: core and DMA each pick by their own mask
    task automatic test_priority();
        cpu_irq_enable = 4'hf;
        dma_irq_enable = 4'h8;
        fork
            ext_irq_requester_i.raise(1);
            ext_irq_requester_i.raise(3);
        join
        wait_pend(3);
        wait_pend(1);
        check_vec(irq_pending, 4'ha);
        fetch_boundary = 1'b1;
        @(negedge clock);
        fetch_boundary = 1'b0;
        check_bit(cpu_irq_take, 1'b1);
        check_vec(cpu_irq_vec, 4'h2);
        check_bit(dma_irq_take, 1'b1);
        check_vec(dma_irq_vec, 4'h8);
        @(negedge clock);
        check_vec(irq_pending, 4'h0);
        check_bit(cpu_irq_take, 1'b0);
    endtask : test_priority

    initial begin
        repeat (5) @(negedge clock);
        check_bit(irq_ack_out, 1'b1);
        check_vec(irq_pending, 4'h0);
        rst_n = 1'b1;
        test_detect();
        test_rate();
        test_ack();
        test_priority();
        final_report();
    end
endmodule : ext_irq_sample_ack_test
